/* logic/ctcm_pkg.sv */
// Purpose: constants and types of the cyclic telegram content mapper
// Assumes: one communication cycle is marked by cycleStrobe; bytes go low byte first
// Notes: telegram type word: bits 2:0 layout, bit 3 encoder-2 feedback, rest reserved
// Summary of operation
// - Timing and structure values are staged in phase 2 and take effect entering phase 3.
// - In phase 4 every feedback field is captured fresh at each cycle strobe that finds the builder idle.
// - Standard or application layout is chosen only by the telegram type value.
// - Standard layouts fix which values travel and in what field order.
// - Type 0 carries no cyclic data; only the fixed record is sent.
// - Type 1 takes a 2-byte torque command from field 1, torque mode.
// - Type 1 feedback telegram holds only the fixed record.
// - Type 2 takes 4-byte velocity command, returns 4-byte velocity feedback.
// - Type 3 takes velocity command, returns 4-byte position feedback.
// - Types 3 to 5 choose encoder 1 or 2 position from the type value.
// - Type 4 takes 4-byte position command, returns position feedback.
// - Type 5 takes position then velocity command, returns position then velocity.
// - Type 5 lets the drive switch between velocity and position control.
// - Type 6 takes velocity command, feedback telegram holds only fixed record.
// - The drive reports its own slave timing limits.
package ctcm_pkg;
	localparam logic [2:0]  PARAMETER_PHASE        = 3'h2;
	localparam logic [2:0]  ACTIVATION_PHASE       = 3'h3;
	localparam logic [2:0]  CYCLIC_OPERATION_PHASE = 3'h4;
	localparam logic [15:0] TYPE_RESET             = 16'h0000;
	localparam logic [15:0] TYPE_RSV_MASK          = 16'hFFF0;
	localparam int          TYPE_ENC2_BIT          = 3;
	localparam logic [2:0]  TYPE_APPLICATION       = 3'h7;
	localparam logic [3:0]  FIX_LEN                = 4'h2;
	localparam int          FIFO_W                 = 8;
	localparam int          FIFO_D                 = 32;
	// Master-programmed values: cycle times, start times, record position, length
	localparam logic [3:0]  PROG_N                 = 4'h8;
	localparam logic [3:0]  LIMIT_BASE             = 4'h8;
	localparam logic [3:0]  LIMIT_N                = 4'h6;
	// Slave limits in ns: shortest start, tx/rx transition, tx and rx recovery,
	// command processing, min feedback processing
	localparam logic [31:0] SLAVE_LIMIT [6] = '{32'h0000_07D0, 32'h0000_0FA0,
		32'h0000_0FA0, 32'h0000_0FA0, 32'h0000_2710, 32'h0000_2710};

	typedef enum logic [1:0] {
		CTCM_MODE_NONE     = 2'h0,
		CTCM_MODE_TORQUE   = 2'h1,
		CTCM_MODE_VELOCITY = 2'h2,
		CTCM_MODE_POSITION = 2'h3
	} ctcm_mode_t;

	typedef enum logic [1:0] {
		BLD_IDLE = 2'h0,
		BLD_FIX  = 2'h1,
		BLD_FLD  = 2'h3
	} ctcm_bld_t;

	function automatic logic [3:0] ctcm_cmd_len(input logic [2:0] t);
		unique case (t)
			3'h1:                 return 4'h2;
			3'h2, 3'h3, 3'h4, 3'h6: return 4'h4;
			3'h5:                 return 4'h8;
			default:              return 4'h0;
		endcase
	endfunction

	function automatic logic [3:0] ctcm_fb_len(input logic [2:0] t);
		unique case (t)
			3'h2, 3'h3, 3'h4: return 4'h4;
			3'h5:             return 4'h8;
			default:          return 4'h0;
		endcase
	endfunction
endpackage

/* logic/ctcm_fifo.sv */
// Purpose: byte FIFO between the feedback builder and the link transmitter
// Assumes: flush empties it in one cycle
// Notes: read data come straight from the storage flip-flops
`timescale 1ns/1ns
module ctcm_fifo #(
	parameter int W = 8,
	parameter int D = 32
)(
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire logic         flush,
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	output logic              outValid,
	input  wire logic         outReady,
	output logic      [W-1:0] outData
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0]   count;
	logic          doWr;
	logic          doRd;

	assign inReady  = count != (AW+1)'(D);
	assign outValid = count != '0;
	assign doWr     = inValid && inReady;
	assign doRd     = outValid && outReady;
	assign outData  = mem[rdPtr];

	always_ff @(posedge sys_clk)
	begin
		if (doWr)
		begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst || flush)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			if (doWr)
			begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (doRd)
			begin
				rdPtr <= rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
		end
	end
endmodule

/* logic/ctcm_mapper.sv */
// Purpose: maps cyclic command and feedback records by telegram type
// Assumes: phase and record inputs synchronous to sys_clk
// Notes: any phase change restarts parser, builder and FIFO
`timescale 1ns/1ns
module ctcm_mapper
	import ctcm_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic [2:0]  phase,
	input  wire logic        cycleStrobe,
	input  wire logic        paramWrite,
	input  wire logic [3:0]  paramAddr,
	input  wire logic [31:0] paramData,
	input  wire logic [3:0]  paramRdAddr,
	output logic      [31:0] paramRdData,
	input  wire logic        typeWrite,
	input  wire logic [15:0] typeValue,
	output logic             typeRejected,
	output logic      [15:0] activeType,
	output logic             appLayout,
	output ctcm_mode_t       controlMode,
	input  wire logic        modeSelPos,
	input  wire logic        cmdRecValid,
	input  wire logic        cmdRecFirst,
	input  wire logic [7:0]  cmdRecByte,
	output logic      [15:0] torqueCmd,
	output logic      [31:0] velocityCmd,
	output logic      [31:0] positionCmd,
	output logic             cmdUpdate,
	input  wire logic [15:0] statusWord,
	input  wire logic [31:0] velocityFb,
	input  wire logic [31:0] positionFb1,
	input  wire logic [31:0] positionFb2,
	output logic             fbRecValid,
	output logic      [7:0]  fbRecByte,
	input  wire logic        fbRecReady,
	output logic             fbBusy,
	output logic             fbLate
);
	logic [2:0]  phasePrev;
	logic        phaseChg;
	logic        actEnter;
	logic        inCyclic;
	logic [15:0] shadowType;
	logic        typeOk;
	logic [2:0]  stdType;
	logic [3:0]  cmdLen;
	logic [31:0] progShadow [8];
	logic [31:0] progActive [8];
	logic [3:0]  rxCnt;
	logic [3:0]  rxIdx;
	logic [63:0] rxAcc;
	logic [63:0] next_rxAcc;
	logic        rxDone;
	ctcm_bld_t   bldState;
	logic [3:0]  bldIdx;
	logic [3:0]  bldLast;
	logic [79:0] snap;
	logic        bldStart;
	logic        pushValid;
	logic        pushReady;
	logic [7:0]  pushByte;

	assign phaseChg = phase != phasePrev;
	assign actEnter = phaseChg && phase == ACTIVATION_PHASE;
	assign inCyclic = phase == CYCLIC_OPERATION_PHASE && !phaseChg;
	assign stdType  = activeType[2:0];
	assign cmdLen   = ctcm_cmd_len(stdType);

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			phasePrev <= 3'h0;
		end
		else
		begin
			phasePrev <= phase;
		end
	end

	// Type value is only taken in phase 2 with reserved bits clear
	assign typeOk = typeWrite && phase == PARAMETER_PHASE
		&& (typeValue & TYPE_RSV_MASK) == 16'h0000;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			shadowType   <= TYPE_RESET;
			typeRejected <= 1'b0;
		end
		else
		begin
			typeRejected <= typeWrite && !typeOk;
			if (typeOk)
			begin
				shadowType <= typeValue;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			activeType <= TYPE_RESET;
		end
		else if (actEnter)
		begin
			activeType <= shadowType;
		end
	end

	// Programmed times follow the same stage-then-activate path as the type
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < 8; i++)
			begin
				progShadow[i] <= 32'h0000_0000;
				progActive[i] <= 32'h0000_0000;
			end
		end
		else
		begin
			if (paramWrite && phase == PARAMETER_PHASE && paramAddr < PROG_N)
			begin
				progShadow[paramAddr[2:0]] <= paramData;
			end
			if (actEnter)
			begin
				progActive <= progShadow;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			paramRdData <= 32'h0000_0000;
		end
		else if (paramRdAddr < PROG_N)
		begin
			paramRdData <= progActive[paramRdAddr[2:0]];
		end
		else if (paramRdAddr < LIMIT_BASE + LIMIT_N)
		begin
			paramRdData <= SLAVE_LIMIT[3'(paramRdAddr - LIMIT_BASE)];
		end
		else
		begin
			paramRdData <= 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			appLayout   <= 1'b0;
			controlMode <= CTCM_MODE_NONE;
		end
		else
		begin
			appLayout <= stdType == TYPE_APPLICATION;
			unique case (stdType)
				3'h1:             controlMode <= CTCM_MODE_TORQUE;
				3'h2, 3'h3, 3'h6: controlMode <= CTCM_MODE_VELOCITY;
				3'h4:             controlMode <= CTCM_MODE_POSITION;
				3'h5:             controlMode <= modeSelPos ? CTCM_MODE_POSITION
					: CTCM_MODE_VELOCITY;
				default:          controlMode <= CTCM_MODE_NONE;
			endcase
		end
	end

	// Command record parser; bytes beyond the eighth are dropped
	assign rxIdx = cmdRecFirst ? 4'h0 : rxCnt;
	assign rxDone = cmdRecValid && cmdLen != 4'h0 && rxIdx + 4'h1 == cmdLen;

	always_comb
	begin
		next_rxAcc = rxAcc;
		if (cmdRecValid && !rxIdx[3])
		begin
			next_rxAcc[{rxIdx[2:0], 3'b000} +: 8] = cmdRecByte;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst || phaseChg)
		begin
			rxAcc <= 64'h0000_0000_0000_0000;
			rxCnt <= 4'h0;
		end
		else
		begin
			rxAcc <= next_rxAcc;
			if (cmdRecValid && !rxIdx[3])
			begin
				rxCnt <= rxIdx + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			torqueCmd   <= 16'h0000;
			velocityCmd <= 32'h0000_0000;
			positionCmd <= 32'h0000_0000;
			cmdUpdate   <= 1'b0;
		end
		else
		begin
			cmdUpdate <= rxDone && inCyclic;
			if (rxDone && inCyclic)
			begin
				unique case (stdType)
					3'h1:             torqueCmd <= next_rxAcc[15:0];
					3'h2, 3'h3, 3'h6: velocityCmd <= next_rxAcc[31:0];
					3'h4:             positionCmd <= next_rxAcc[31:0];
					3'h5:
					begin
						positionCmd <= next_rxAcc[31:0];
						velocityCmd <= next_rxAcc[63:32];
					end
					default: ;
				endcase
			end
		end
	end

	// Feedback builder: a cycle strobe while still busy means the link is too slow
	assign bldStart  = cycleStrobe && inCyclic && bldState == BLD_IDLE;
	assign pushValid = bldState != BLD_IDLE;
	assign pushByte  = snap[{bldIdx, 3'b000} +: 8];
	assign fbBusy    = pushValid;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			snap    <= 80'h0;
			bldLast <= 4'h0;
		end
		else if (bldStart)
		begin
			snap[15:0] <= statusWord;
			unique case (stdType)
				3'h2:             snap[47:16] <= velocityFb;
				3'h3, 3'h4, 3'h5: snap[47:16] <= activeType[TYPE_ENC2_BIT]
					? positionFb2 : positionFb1;
				default:          snap[47:16] <= 32'h0000_0000;
			endcase
			snap[79:48] <= stdType == 3'h5 ? velocityFb : 32'h0000_0000;
			bldLast <= FIX_LEN + ctcm_fb_len(stdType) - 4'h1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst || phaseChg)
		begin
			bldState <= BLD_IDLE;
			bldIdx   <= 4'h0;
		end
		else
		begin
			unique case (bldState)
				BLD_IDLE:
				begin
					bldIdx <= 4'h0;
					if (bldStart)
					begin
						bldState <= BLD_FIX;
					end
				end
				BLD_FIX:
				begin
					if (pushReady)
					begin
						bldIdx <= bldIdx + 4'h1;
						if (bldIdx == FIX_LEN - 4'h1)
						begin
							bldState <= bldIdx == bldLast ? BLD_IDLE : BLD_FLD;
						end
					end
				end
				BLD_FLD:
				begin
					if (pushReady)
					begin
						bldIdx <= bldIdx + 4'h1;
						if (bldIdx == bldLast)
						begin
							bldState <= BLD_IDLE;
						end
					end
				end
				default: bldState <= BLD_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			fbLate <= 1'b0;
		end
		else if (cycleStrobe && inCyclic && bldState != BLD_IDLE)
		begin
			fbLate <= 1'b1;
		end
		else if (phaseChg)
		begin
			fbLate <= 1'b0;
		end
	end

	ctcm_fifo #(
		.W (FIFO_W),
		.D (FIFO_D)
	) u_fifo (
		.sys_clk  (sys_clk),
		.srst     (srst),
		.flush    (phaseChg),
		.inValid  (pushValid),
		.inReady  (pushReady),
		.inData   (pushByte),
		.outValid (fbRecValid),
		.outReady (fbRecReady),
		.outData  (fbRecByte)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_act_hold;
		!actEnter |=> $stable(activeType);
	endproperty
	a_act_hold: assert property (p_act_hold) else $error("type changed outside entry");

	property p_act_copy;
		actEnter |=> activeType == $past(shadowType);
	endproperty
	a_act_copy: assert property (p_act_copy) else $error("type not activated");

	property p_reject;
		typeWrite && (typeValue & TYPE_RSV_MASK) != 16'h0000
			|=> typeRejected && $stable(shadowType);
	endproperty
	a_reject: assert property (p_reject) else $error("bad type not refused");

	property p_torque;
		rxDone && inCyclic && stdType == 3'h1 |=> cmdUpdate
			&& torqueCmd == $past(next_rxAcc[15:0]);
	endproperty
	a_torque: assert property (p_torque) else $error("torque not taken");

	property p_vel5;
		rxDone && inCyclic && stdType == 3'h5 |=> velocityCmd == $past(next_rxAcc[63:32])
			&& positionCmd == $past(next_rxAcc[31:0]);
	endproperty
	a_vel5: assert property (p_vel5) else $error("type 5 commands wrong");

	property p_mode5;
		stdType == 3'h5 && $stable(stdType) |=> controlMode == ($past(modeSelPos)
			? CTCM_MODE_POSITION : CTCM_MODE_VELOCITY);
	endproperty
	a_mode5: assert property (p_mode5) else $error("type 5 mode wrong");

	sequence s_start;
		bldStart && !srst;
	endsequence
	sequence s_fix_first;
		bldState == BLD_FIX && bldIdx == 4'h0 ##0 pushByte == $past(statusWord[7:0]);
	endsequence
	property p_fix_first;
		s_start |=> s_fix_first;
	endproperty
	a_fix_first: assert property (p_fix_first) else $error("fixed record not first");

	property p_fresh;
		s_start |=> snap[15:0] == $past(statusWord);
	endproperty
	a_fresh: assert property (p_fresh) else $error("feedback not captured");

	property p_enc;
		s_start ##0 (stdType == 3'h3 || stdType == 3'h4) |=> snap[47:16]
			== ($past(activeType[TYPE_ENC2_BIT]) ? $past(positionFb2) : $past(positionFb1));
	endproperty
	a_enc: assert property (p_enc) else $error("encoder choice wrong");

	property p_len;
		pushValid && pushReady && bldIdx == bldLast && !phaseChg |=> bldState == BLD_IDLE;
	endproperty
	a_len: assert property (p_len) else $error("record length wrong");

	property p_type1_len;
		s_start ##0 stdType == 3'h1 |=> bldLast == FIX_LEN - 4'h1;
	endproperty
	a_type1_len: assert property (p_type1_len) else $error("type 1 not fixed only");
endmodule

/* dv/ctcm_master_model.sv */
// Purpose: fieldbus master model that sends command records and takes feedback bytes
// Assumes: send is called from the bench; each transfer starts at a clock edge
// Notes: pace 0 takes every byte, 1 takes one in three, 2 stalls so the FIFO backs up
`timescale 1ns/1ns
module ctcm_master_model (
	input  wire logic       sys_clk,
	input  wire logic [1:0] pace,
	output logic            cmdRecValid,
	output logic            cmdRecFirst,
	output logic [7:0]      cmdRecByte,
	input  wire logic       fbRecValid,
	input  wire logic [7:0] fbRecByte,
	output logic            fbRecReady
);
	logic [7:0] rxq [$];
	logic [1:0] tick = 2'h0;
	initial
	begin
		cmdRecValid = 1'b0;
		cmdRecFirst = 1'b0;
		cmdRecByte  = 8'h00;
		fbRecReady  = 1'b0;
	end
	always @(posedge sys_clk)
	begin
		tick <= (tick == 2'h2) ? 2'h0 : tick + 2'h1;
		fbRecReady <= pace == 2'h0 || (pace == 2'h1 && tick == 2'h0);
		if (fbRecValid && fbRecReady)
			rxq.push_back(fbRecByte);
	end
	// Whole record, bytes back to back, low byte first
	task automatic send(input logic [63:0] v, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge sys_clk);
			cmdRecValid <= 1'b1;
			cmdRecFirst <= (i == 0);
			cmdRecByte  <= v[8*i+:8];
		end
		@(posedge sys_clk);
		cmdRecValid <= 1'b0;
		cmdRecFirst <= 1'b0;
		// Released line shows the inverse so a stale byte cannot pass as fresh
		cmdRecByte  <= ~v[8*(n-1)+:8];
		#1;
	endtask
endmodule

/* dv/test_ctcm_mapper.sv */
// Purpose: self-checking bench of the cyclic telegram content mapper
// Assumes: phase codes and slave limits come from the package constants
// Notes: walks every telegram type through phases 2, 3 and 4, then refusals and a full FIFO
`timescale 1ns/1ns
module test_ctcm_mapper
	import ctcm_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic [2:0]  phase = 3'h0;
	logic        cycleStrobe = 1'b0, paramWrite = 1'b0, typeWrite = 1'b0, modeSelPos = 1'b1;
	logic [1:0]  pace = 2'h0;
	logic [3:0]  paramAddr = 4'h0, paramRdAddr = 4'h0;
	logic [31:0] paramData = 32'h0, paramRdData, velocityCmd, positionCmd;
	logic [15:0] typeValue = 16'h0, activeType, torqueCmd, statusWord = 16'hA55A;
	logic [31:0] velocityFb = 32'h0, positionFb1 = 32'h0, positionFb2 = 32'h0;
	logic        typeRejected, appLayout, cmdUpdate, fbRecValid, fbRecReady, fbBusy, fbLate;
	logic        cmdRecValid, cmdRecFirst;
	logic [7:0]  cmdRecByte, fbRecByte;
	ctcm_mode_t  controlMode;
	int          errors = 0, total_checks = 0, rejCount = 0, updCount = 0;

	ctcm_mapper uut (.sys_clk, .srst, .phase, .cycleStrobe, .paramWrite, .paramAddr, .paramData,
		.paramRdAddr, .paramRdData, .typeWrite, .typeValue, .typeRejected, .activeType,
		.appLayout, .controlMode, .modeSelPos, .cmdRecValid, .cmdRecFirst, .cmdRecByte,
		.torqueCmd, .velocityCmd, .positionCmd, .cmdUpdate, .statusWord, .velocityFb,
		.positionFb1, .positionFb2, .fbRecValid, .fbRecByte, .fbRecReady, .fbBusy, .fbLate);
	ctcm_master_model mm (.sys_clk, .pace, .cmdRecValid, .cmdRecFirst, .cmdRecByte,
		.fbRecValid, .fbRecByte, .fbRecReady);

	initial
	begin
		forever #10 sys_clk = ~sys_clk;
	end
	// Pulses are counted so a check never depends on catching the exact cycle
	always @(posedge sys_clk)
	begin
		if (typeRejected === 1'b1)
			rejCount <= rejCount + 1;
		if (cmdUpdate === 1'b1)
			updCount <= updCount + 1;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wrParam(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		paramWrite <= 1'b1;
		paramAddr  <= a;
		paramData  <= d;
		@(posedge sys_clk);
		paramWrite <= 1'b0;
	endtask
	task automatic rdParam(input logic [3:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		paramRdAddr <= a;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(paramRdData, exp, "parameter");
	endtask
	task automatic pulseType(input logic [15:0] tv);
		@(posedge sys_clk);
		typeValue <= tv;
		typeWrite <= 1'b1;
		@(posedge sys_clk);
		typeWrite <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	task automatic goType(input logic [15:0] tv, input int rej);
		int r0;
		r0 = rejCount;
		@(posedge sys_clk);
		phase <= PARAMETER_PHASE;
		pulseType(tv);
		chk(rejCount - r0, rej, "refusals");
		@(posedge sys_clk);
		phase <= ACTIVATION_PHASE;
		repeat (3) @(posedge sys_clk);
		phase <= CYCLIC_OPERATION_PHASE;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	task automatic strobe();
		@(posedge sys_clk);
		cycleStrobe <= 1'b1;
		@(posedge sys_clk);
		cycleStrobe <= 1'b0;
	endtask
	task automatic waitRx(input int len);
		int w;
		for (w = 0; w < 300 && !(mm.rxq.size() == len && fbBusy === 1'b0); w++)
			@(posedge sys_clk);
		repeat (3) @(posedge sys_clk);
		#1;
		if (w == 300)
		begin
			errors++;
			$display("ERROR %0t: feedback never completed", $time);
			results();
		end
		chk(mm.rxq.size(), len, "feedback length");
	endtask

	initial
	begin
		logic [63:0] cmd, fv;
		logic [15:0] tv;
		logic [7:0]  e [$];
		int          n, k, u0;
		repeat (4) @(posedge sys_clk);
		srst  <= 1'b0;
		phase <= PARAMETER_PHASE;
		for (int i = 0; i < 8; i++)
			wrParam(i[3:0], 32'hC0DE_0000 + i);
		rdParam(4'h0, 32'h0);
		goType(16'h0000, 0);
		for (int i = 0; i < 15; i++)
			rdParam(i[3:0], (i < 8) ? 32'hC0DE_0000 + i : (i < 14) ? SLAVE_LIMIT[i-8] : 0);
		$display("parameter test done");
		for (int t = 0; t < 8; t++)
		begin
			n   = (t == 1) ? 2 : (t == 5) ? 8 : (t == 0 || t == 7) ? 0 : 4;
			cmd = 64'hF0E1_D2C3_B4A5_9680 + t;
			tv  = {12'h000, t == 3 || t == 5, t[2:0]};
			@(posedge sys_clk);
			velocityFb  <= 32'h1122_3340 + t;
			positionFb1 <= 32'h5566_7780 + t;
			positionFb2 <= 32'h99AA_BBC0 + t;
			statusWord  <= 16'hA550 + t[15:0];
			pace        <= (t == 5) ? 2'h1 : 2'h0;
			modeSelPos  <= 1'b1;
			goType(tv, 0);
			chk(activeType, tv, "active type");
			chk(appLayout, t == 7, "layout kind");
			chk(controlMode, (t == 0 || t == 7) ? CTCM_MODE_NONE : (t == 1) ? CTCM_MODE_TORQUE :
				(t == 4 || t == 5) ? CTCM_MODE_POSITION : CTCM_MODE_VELOCITY, "mode");
			u0 = updCount;
			mm.send(cmd, (n == 0) ? 4 : n);
			repeat (4) @(posedge sys_clk);
			#1;
			chk(updCount - u0, n != 0, "command updates");
			if (t == 1)
				chk(torqueCmd, cmd[15:0], "torque");
			if (t == 2 || t == 3 || t == 6)
				chk(velocityCmd, cmd[31:0], "velocity");
			if (t == 4 || t == 5)
				chk(positionCmd, cmd[31:0], "position");
			if (t == 5)
				chk(velocityCmd, cmd[63:32], "second velocity");
			e  = {statusWord[7:0], statusWord[15:8]};
			fv = {velocityFb, (t == 2) ? velocityFb : tv[3] ? positionFb2 : positionFb1};
			k  = (t == 5) ? 8 : (t >= 2 && t <= 4) ? 4 : 0;
			for (int b = 0; b < k; b++)
				e.push_back(fv[8*b+:8]);
			mm.rxq.delete();
			strobe();
			if (t == 5)
				strobe();
			waitRx(e.size());
			for (int b = 0; b < e.size() && b < mm.rxq.size(); b++)
				chk(mm.rxq[b], e[b], "feedback byte");
			if (t == 5)
			begin
				chk(fbLate, 1'b1, "late strobe");
				@(posedge sys_clk);
				modeSelPos <= 1'b0;
				repeat (3) @(posedge sys_clk);
				#1;
				chk(controlMode, CTCM_MODE_VELOCITY, "mode switch");
				chk(activeType, tv, "layout kept");
			end
			$display("telegram type %0d done", t);
		end
		goType(16'h0015, 1);
		chk(activeType, 16'h0007, "kept type");
		u0 = rejCount;
		pulseType(16'h0002);
		chk(rejCount - u0, 1, "write in phase 4");
		wrParam(4'h0, 32'hDEAD_BEEF);
		goType(16'h000D, 0);
		rdParam(4'h0, 32'hC0DE_0000);
		$display("refusal test done");
		// Four records of ten bytes overrun the 32-byte FIFO while the master stalls
		mm.rxq.delete();
		@(posedge sys_clk);
		pace <= 2'h2;
		for (int r = 0; r < 4; r++)
		begin
			strobe();
			repeat (14) @(posedge sys_clk);
		end
		#1;
		chk({fbBusy, fbRecValid}, 2'h3, "full FIFO holds builder");
		@(posedge sys_clk);
		pace <= 2'h1;
		waitRx(40);
		chk(mm.rxq[39], velocityFb[31:24], "last drained byte");
		$display("buffer test done");
		results();
	end
endmodule
